// File: src/codec_ctrl_pkg.sv
// constants and carrier types for the codec control word register bank
// Function
// R1 - hardware reset pin clears every control register to zero
// R2 - zero reset state selects serial clock over eight, sample rate over 2048
// R3 - writing one to software reset bit resets like the reset pin
// R4 - hardware and software reset complete within four divided master clock cycles
// R5 - after any reset operating mode bit reads zero, program mode
// R6 - host reprograms control registers after every power-up or reset
// R7 - first output frame sync comes 2048 divided clocks after reset release
// R8 - output words in program mode carry random content, host ignores them
// R9 - global power-on set powers every section regardless of section bits; the code leaves the reference pin output to its own bit 6
// R10 - global power-on clear powers each section by its own bit
// R11 - bit 15 marks a control word; zero in program mode is ignored
// R12 - bit 14 zero and device address zero writes data into chosen register
// R13 - bit 14 one and addressed here returns register contents in shifted word
// R14 - device address zero selects this device; nonzero is decremented and forwarded
// R15 - bits 10 to 8 pick one of six control registers, 000 to 101
// R16 - bits 7 to 0 carry the value written or read back
// R17 - first register bits 0 to 3: mode, mixed, digital loop, port loop
// R18 - first register bits 4 to 6 device count, bit 7 software reset
// R19 - second register: sample rate, serial clock divider, master divider, echo
// R20 - power register: global, converter in, converter out, reference, reference pin
// R21 - host writes zero to reserved power register bits 1, 2, 7
// R22 - control registers update on falling serial clock edge
// R23 - master divider codes 000 to 100 divide one to five, others one
// R24 - serial clock codes give divided clock over eight, four, two, one; code 3 divides by one only at master ratios two and four
// R25 - sample rate codes give divided clock over 2048, 1024, 512, 256
// R26 - register address 110 or 111 leaves all control registers unchanged
package codec_ctrl_pkg;

  localparam logic [2:0] REG_MODE = 3'h0;
  localparam logic [2:0] REG_CLOCK = 3'h1;
  localparam logic [2:0] REG_POWER = 3'h2;
  localparam logic [2:0] REG_GAIN = 3'h3;
  localparam logic [2:0] REG_TIMING = 3'h4;
  localparam logic [2:0] REG_ROUTING = 3'h5;
  localparam int REG_COUNT = 6;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  localparam int MODE_OPERATING_BIT = 0;
  localparam int MODE_MIXED_BIT = 1;
  localparam int MODE_DIGITAL_LOOP_BIT = 2;
  localparam int MODE_PORT_LOOP_BIT = 3;
  localparam int MODE_COUNT_LSB = 4;
  localparam int MODE_SOFT_RESET_BIT = 7;
  localparam int CLOCK_RATE_LSB = 0;
  localparam int CLOCK_SERIAL_LSB = 2;
  localparam int CLOCK_MASTER_LSB = 4;
  localparam int CLOCK_ECHO_BIT = 7;
  localparam int POWER_GLOBAL_BIT = 0;
  localparam int POWER_CONV_IN_BIT = 3;
  localparam int POWER_CONV_OUT_BIT = 4;
  localparam int POWER_REFERENCE_BIT = 5;
  localparam int POWER_REF_PIN_BIT = 6;

  localparam int WORD_BITS = 16;
  localparam logic [2:0] RESET_DIVIDED_MASTER_CLOCK_CYCLES = 3'h4;
  localparam logic [11:0] SLOWEST_SAMPLE_DIV = 12'h800;

  typedef struct packed {
    logic is_control;
    logic is_read;
    logic [2:0] dev_addr;
    logic [2:0] reg_addr;
    logic [7:0] data;
  } ctrl_word_t;

  typedef struct packed {
    logic operating_mode_select;
    logic mixed_operation_enable;
    logic digital_loop_back_enable;
    logic serial_port_loop_back_enable;
    logic [2:0] device_count;
    logic control_echo_enable;
    logic [1:0] sample_rate;
    logic [1:0] serial_divider;
    logic [2:0] master_divider;
  } mode_state_t;

  typedef struct packed {
    logic converter_in_power_on;
    logic converter_out_power_on;
    logic reference_power_on;
    logic reference_output_enable;
  } power_state_t;

endpackage : codec_ctrl_pkg

// File: src/codec_control_word_register_bank.sv
// serial control word interpreter and six control registers of the codec
`timescale 1ns/1ns
module codec_control_word_register_bank (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic serial_data_i,
  input wire logic input_frame_sync_i,
  output logic serial_data_o,
  output logic output_frame_sync_o,
  output logic serial_clock_o,
  output logic divided_master_clock_o,
  output logic reset_busy_o,
  output codec_ctrl_pkg::mode_state_t mode_o,
  output codec_ctrl_pkg::power_state_t power_o,
  output logic [7:0] gain_control_o,
  output logic [7:0] output_timing_control_o,
  output logic [7:0] analog_routing_control_o
);

  // divided master clock ratio
  function automatic logic [2:0] master_ratio(input logic [2:0] code);
    if (code <= 3'h4) begin // R23
      master_ratio = code + 3'h1;
    end else begin
      master_ratio = 3'h1;
    end
  endfunction : master_ratio

  // serial clock half period in core cycles; the undivided rate is
  // clamped to one core cycle per half, so it runs at half the core clock
  function automatic logic [4:0] serial_half(input logic [2:0] ratio, input logic [1:0] code);
    logic [4:0] r;
    r = {2'h0, ratio};
    unique case (code) // R24
      2'h0: serial_half = r << 2;
      2'h1: serial_half = r << 1;
      2'h2: serial_half = r;
      2'h3: serial_half = (r > 5'h1) ? (r >> 1) : 5'h1;
    endcase
  endfunction : serial_half

  // divided clock cycles between sample events
  function automatic logic [11:0] sample_len(input logic [1:0] code);
    sample_len = codec_ctrl_pkg::SLOWEST_SAMPLE_DIV >> code; // R25 R2
  endfunction : sample_len

  logic [7:0] ctrl_reg [0:codec_ctrl_pkg::REG_COUNT-1];
  logic [2:0] mdiv_cnt;
  logic dm_tick;
  logic [2:0] ratio;
  logic [2:0] rst_cnt;
  logic busy;
  logic [4:0] sclk_cnt;
  logic [4:0] half;
  logic sclk;
  logic sclk_edge;
  logic sclk_fall;
  logic sclk_rise;
  logic [1:0] sdi_sync;
  logic [1:0] fs_sync;
  logic [15:0] rx_shift;
  logic [4:0] rx_cnt;
  logic rx_last;
  logic [15:0] rx_word;
  codec_ctrl_pkg::ctrl_word_t cw;
  logic mine;
  logic accept;
  logic do_write;
  logic do_read;
  logic do_fwd;
  logic soft_req;
  logic [7:0] read_val;
  logic [11:0] smp_cnt;
  logic sample_tick;
  logic sample_pend;
  logic reply_pend;
  logic [15:0] reply_word;
  logic [15:0] tx_shift;
  logic [4:0] tx_cnt;
  logic tx_start;
  logic [15:0] next_reply;

  assign ratio = master_ratio(ctrl_reg[codec_ctrl_pkg::REG_CLOCK][codec_ctrl_pkg::CLOCK_MASTER_LSB +: 3]);

  // divided master clock as a one-cycle tick
  // compared with >= so lowering the ratio never strands the counter
  assign dm_tick = (mdiv_cnt >= ratio - 3'h1);
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || dm_tick) begin
      mdiv_cnt <= 3'h0;
    end else begin
      mdiv_cnt <= mdiv_cnt + 3'h1;
    end
  end

  // reset sequence: registers held clear for four divided clock cycles
  // the pin reloads the count, so a reset inside the sequence restarts it
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || soft_req) begin
      rst_cnt <= codec_ctrl_pkg::RESET_DIVIDED_MASTER_CLOCK_CYCLES; // R1 R3 R4
    end else if (dm_tick && busy) begin
      rst_cnt <= rst_cnt - 3'h1; // R4
    end
  end
  assign busy = |rst_cnt;

  // serial clock generated from the divided master clock
  // held low while busy, so the host never sees a partial bit
  assign half = serial_half(ratio, ctrl_reg[codec_ctrl_pkg::REG_CLOCK][codec_ctrl_pkg::CLOCK_SERIAL_LSB +: 2]);
  assign sclk_edge = (sclk_cnt >= half - 5'h1);
  assign sclk_fall = sclk_edge && sclk;
  assign sclk_rise = sclk_edge && !sclk;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || busy || sclk_edge) begin
      sclk_cnt <= 5'h0;
    end else begin
      sclk_cnt <= sclk_cnt + 5'h1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || busy) begin
      sclk <= 1'b0;
    end else if (sclk_edge) begin
      sclk <= !sclk;
    end
  end

  // pins from the host pass two flops first
  // two cycles of latency, so the host changes data on the rising serial clock
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sdi_sync <= 2'h0;
      fs_sync <= 2'h0;
    end else begin
      sdi_sync <= {sdi_sync[0], serial_data_i};
      fs_sync <= {fs_sync[0], input_frame_sync_i};
    end
  end

  // receive: frame sync seen with the first bit, msb first
  // a frame sync seen mid-word is ignored until the receiver is idle
  assign rx_word = {rx_shift[14:0], sdi_sync[1]};
  assign rx_last = sclk_fall && (rx_cnt == 5'(codec_ctrl_pkg::WORD_BITS - 1));
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || busy) begin
      rx_shift <= 16'h0000;
      rx_cnt <= 5'h0;
    end else if (sclk_fall) begin
      if (rx_cnt != 5'h0 || fs_sync[1]) begin
        rx_shift <= rx_word;
        rx_cnt <= rx_last ? 5'h0 : rx_cnt + 5'h1;
      end
    end
  end

  // control word decode, acted on at the falling edge closing the word
  assign cw = codec_ctrl_pkg::ctrl_word_t'(rx_word);
  assign mine = (cw.dev_addr == 3'h0); // R14
  // a word with bit 15 low is ignored; in mixed mode it is sample data
  // data mode without mixed drops every word until a hardware reset
  assign accept = rx_last && cw.is_control && !busy // R11
    && (!mode_o.operating_mode_select || mode_o.mixed_operation_enable);
  assign do_write = accept && mine && !cw.is_read // R12
    && (cw.reg_addr <= codec_ctrl_pkg::REG_ROUTING); // R15 R26
  assign do_read = accept && mine && cw.is_read; // R13
  assign do_fwd = accept && !mine; // R14
  assign soft_req = do_write && (cw.reg_addr == codec_ctrl_pkg::REG_MODE)
    && cw.data[codec_ctrl_pkg::MODE_SOFT_RESET_BIT]; // R3 R18

  always_comb begin
    if (cw.reg_addr <= codec_ctrl_pkg::REG_ROUTING) begin
      read_val = ctrl_reg[cw.reg_addr]; // R15 R16
    end else begin
      read_val = 8'h00;
    end
  end

  // read replies keep device address zero; forwards carry it decremented
  always_comb begin
    next_reply = rx_word;
    if (do_read) begin
      next_reply[7:0] = read_val; // R13 R16
    end else begin
      next_reply[13:11] = cw.dev_addr - 3'h1; // R14
    end
  end

  // control registers; a software reset clears rather than storing bit 7
  // writes to addresses six and seven fall through and change nothing
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || busy || soft_req) begin
      for (int i = 0; i < codec_ctrl_pkg::REG_COUNT; i++) begin
        ctrl_reg[i] <= codec_ctrl_pkg::REG_RESET_VALUE; // R1 R2 R5
      end
    end else if (do_write) begin
      ctrl_reg[cw.reg_addr] <= cw.data; // R12 R16 R22
    end
  end

  // sample events; counting starts at reset release, not at end of busy
  // a rate change acts one cycle late, through the registered field copy
  assign sample_tick = dm_tick && (smp_cnt >= sample_len(mode_o.sample_rate) - 12'h001);
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || soft_req || sample_tick) begin
      smp_cnt <= 12'h000; // R7
    end else if (dm_tick) begin
      smp_cnt <= smp_cnt + 12'h001;
    end
  end

  assign tx_start = sclk_rise && (tx_cnt == 5'h0) && (reply_pend || sample_pend);

  // pending flags: a new event wins over the clear
  // one-deep reply queue: a newer reply overwrites an unsent older one
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || busy) begin
      sample_pend <= 1'b0;
    end else if (sample_tick) begin
      sample_pend <= 1'b1; // R7
    end else if (tx_start && !reply_pend) begin
      sample_pend <= 1'b0;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || busy) begin
      reply_pend <= 1'b0;
      reply_word <= 16'h0000;
    end else if (do_read || do_fwd) begin
      reply_pend <= 1'b1; // R13 R14
      reply_word <= next_reply;
    end else if (tx_start) begin
      reply_pend <= 1'b0;
    end
  end

  // transmit on rising serial clock; replies go before the sample word,
  // which is stale serial content with no meaning outside data modes
  // a frame cut short by reset is dropped; the host must resend it
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || busy) begin
      tx_shift <= 16'h0000;
      tx_cnt <= 5'h0;
      output_frame_sync_o <= 1'b0;
    end else if (tx_start) begin
      tx_shift <= reply_pend ? reply_word : rx_shift; // R8 R13 R14
      tx_cnt <= 5'(codec_ctrl_pkg::WORD_BITS);
      output_frame_sync_o <= 1'b1; // R7
    end else if (sclk_rise && tx_cnt != 5'h0) begin
      tx_shift <= {tx_shift[14:0], 1'b0};
      tx_cnt <= tx_cnt - 5'h1;
      output_frame_sync_o <= 1'b0;
    end
  end

  // decoded register fields
  // one cycle behind the registers, so every field changes together
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mode_o <= '0;
    end else begin
      mode_o.operating_mode_select <=
        ctrl_reg[codec_ctrl_pkg::REG_MODE][codec_ctrl_pkg::MODE_OPERATING_BIT]; // R17 R5
      mode_o.mixed_operation_enable <= ctrl_reg[codec_ctrl_pkg::REG_MODE][codec_ctrl_pkg::MODE_MIXED_BIT];
      mode_o.digital_loop_back_enable <=
        ctrl_reg[codec_ctrl_pkg::REG_MODE][codec_ctrl_pkg::MODE_DIGITAL_LOOP_BIT];
      mode_o.serial_port_loop_back_enable <=
        ctrl_reg[codec_ctrl_pkg::REG_MODE][codec_ctrl_pkg::MODE_PORT_LOOP_BIT];
      mode_o.device_count <= ctrl_reg[codec_ctrl_pkg::REG_MODE][codec_ctrl_pkg::MODE_COUNT_LSB +: 3]; // R18
      mode_o.control_echo_enable <= ctrl_reg[codec_ctrl_pkg::REG_CLOCK][codec_ctrl_pkg::CLOCK_ECHO_BIT]; // R19
      mode_o.sample_rate <= ctrl_reg[codec_ctrl_pkg::REG_CLOCK][codec_ctrl_pkg::CLOCK_RATE_LSB +: 2];
      mode_o.serial_divider <= ctrl_reg[codec_ctrl_pkg::REG_CLOCK][codec_ctrl_pkg::CLOCK_SERIAL_LSB +: 2];
      mode_o.master_divider <= ctrl_reg[codec_ctrl_pkg::REG_CLOCK][codec_ctrl_pkg::CLOCK_MASTER_LSB +: 3];
    end
  end

  // power: global bit overrides for both converters and the reference, otherwise each section's own bit; reference pin uses its own bit only
  // reserved power bits are stored for read-back but drive nothing
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      power_o <= '0;
    end else begin
      power_o.converter_in_power_on <=
        ctrl_reg[codec_ctrl_pkg::REG_POWER][codec_ctrl_pkg::POWER_GLOBAL_BIT] // R9
        | ctrl_reg[codec_ctrl_pkg::REG_POWER][codec_ctrl_pkg::POWER_CONV_IN_BIT]; // R10 R20
      power_o.converter_out_power_on <=
        ctrl_reg[codec_ctrl_pkg::REG_POWER][codec_ctrl_pkg::POWER_GLOBAL_BIT] // R9
        | ctrl_reg[codec_ctrl_pkg::REG_POWER][codec_ctrl_pkg::POWER_CONV_OUT_BIT]; // R10 R20
      power_o.reference_power_on <=
        ctrl_reg[codec_ctrl_pkg::REG_POWER][codec_ctrl_pkg::POWER_GLOBAL_BIT] // R9
        | ctrl_reg[codec_ctrl_pkg::REG_POWER][codec_ctrl_pkg::POWER_REFERENCE_BIT]; // R10 R20
      power_o.reference_output_enable <=
        ctrl_reg[codec_ctrl_pkg::REG_POWER][codec_ctrl_pkg::POWER_REF_PIN_BIT]; // R20
    end
  end

  // analog register fields are not decoded here; raw copies go out
  assign gain_control_o = ctrl_reg[codec_ctrl_pkg::REG_GAIN];
  assign output_timing_control_o = ctrl_reg[codec_ctrl_pkg::REG_TIMING];
  assign analog_routing_control_o = ctrl_reg[codec_ctrl_pkg::REG_ROUTING];
  assign serial_data_o = tx_shift[15];
  assign serial_clock_o = sclk;
  assign divided_master_clock_o = dm_tick;
  assign reset_busy_o = busy;

endmodule : codec_control_word_register_bank

// File: verif/codec_ctrl_props.sv
// port-level property checker for the codec control word register bank
`timescale 1ns/1ns
module codec_ctrl_props (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic serial_clock_o,
  input wire logic output_frame_sync_o,
  input wire logic divided_master_clock_o,
  input wire logic reset_busy_o,
  input wire codec_ctrl_pkg::mode_state_t mode_o,
  input wire codec_ctrl_pkg::power_state_t power_o,
  input wire logic [7:0] gain_control_o,
  input wire logic [7:0] output_timing_control_o,
  input wire logic [7:0] analog_routing_control_o
);
  logic [11:0] ticks;
  logic [23:0] raw;
  assign raw = {gain_control_o, output_timing_control_o, analog_routing_control_o};
  // saturates so a long run cannot wrap back under the first sync point
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) ticks <= 12'h000;
    else if (divided_master_clock_o && ticks != 12'hfff) ticks <= ticks + 12'h001;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_SCLK_QUIET: assert property (reset_busy_o |-> !serial_clock_o) else $error("serial clock during reset");
  AST_BUSY_SPAN: assert property ($rose(reset_busy_o) |-> reset_busy_o [*4] ##1 !reset_busy_o)
    else $error("reset sequence length wrong");
  AST_CLEARED: assert property (reset_busy_o && $past(reset_busy_o) |-> mode_o == '0 && power_o == '0 && raw == '0)
    else $error("registers not cleared by reset");
  AST_DIVIDED_MASTER_CLOCK_BUSY: assert property (reset_busy_o |-> divided_master_clock_o)
    else $error("divided clock not undivided after reset");
  AST_SCLK_SLOW: assert property ($rose(serial_clock_o) && mode_o.serial_divider == 2'h0
    && mode_o.master_divider == 3'h0 |-> serial_clock_o [*4] ##1 !serial_clock_o) else $error("slow serial clock wrong");
  AST_FS_ON_RISE: assert property ($rose(output_frame_sync_o) |-> serial_clock_o)
    else $error("frame sync off serial clock rise");
  AST_FS_NOT_EARLY: assert property ($rose(output_frame_sync_o) |-> ticks >= 12'h7ff)
    else $error("first frame sync too early");
  AST_REG_ON_FALL: assert property ($changed(raw) |-> ##[0:1] !serial_clock_o)
    else $error("register changed in serial clock high phase");
endmodule : codec_ctrl_props
bind codec_control_word_register_bank codec_ctrl_props i_codec_ctrl_props (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .serial_clock_o(serial_clock_o), .output_frame_sync_o(output_frame_sync_o),
  .divided_master_clock_o(divided_master_clock_o), .reset_busy_o(reset_busy_o), .mode_o(mode_o),
  .power_o(power_o), .gain_control_o(gain_control_o), .output_timing_control_o(output_timing_control_o),
  .analog_routing_control_o(analog_routing_control_o));

// File: verif/host_port_model.sv
// host serial port model that sends control words and captures replies
`timescale 1ns/1ns
module host_port_model (
  input wire logic core_clk_i,
  input wire logic serial_clock_i,
  input wire logic reply_data_i,
  input wire logic reply_sync_i,
  output logic serial_data_o,
  output logic frame_sync_o
);
  logic seen = 1'b0;
  initial begin
    serial_data_o = 1'b0;
    frame_sync_o = 1'b0;
  end
  task automatic next_edge(input logic rise);
    do begin
      seen = serial_clock_i;
      @(negedge core_clk_i);
    end while (!(serial_clock_i == rise && seen == !rise));
  endtask : next_edge
  // data changes on the serial clock rise, half a period clear of sampling
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      next_edge(1'b1);
      frame_sync_o <= (i == 15);
      serial_data_o <= w[i];
    end
    next_edge(1'b1);
    serial_data_o <= ~w[0];
  endtask : send_word
  task automatic get_reply(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      next_edge(1'b0);
      w[i] = reply_data_i;
    end
  endtask : get_reply
  // words are timed off a sample event; its content is never used
  task automatic wait_sample();
    int n;
    n = 0;
    while (reply_sync_i && n < 4200) begin
      @(negedge core_clk_i);
      n++;
    end
    while (!reply_sync_i && n < 4200) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask : wait_sample
endmodule : host_port_model

// File: verif/tb_codec_control_word_register_bank.sv
// self-checking bench for the codec control word register bank
`timescale 1ns/1ns
module tb_codec_control_word_register_bank;
  typedef struct packed {logic [2:0] sel; logic [7:0] wr; logic [7:0] rd;} row_t;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sdi, fsi, sdo, fso, sclk, busy;
  codec_ctrl_pkg::mode_state_t mode;
  codec_ctrl_pkg::power_state_t power;
  logic [7:0] gain, timing, routing;
  logic [15:0] reply;
  int mismatches = 0;
  int check_count = 0;
  int n;
  // dividers stay at zero so the host timing holds throughout
  row_t rows [8] = '{'{3'h0, 8'h70, 8'h70}, '{3'h1, 8'h80, 8'h80}, '{3'h2, 8'h38, 8'h38},
    '{3'h3, 8'ha5, 8'ha5}, '{3'h4, 8'h3f, 8'h3f}, '{3'h5, 8'he0, 8'he0}, '{3'h6, 8'h55, 8'h00},
    '{3'h7, 8'h5a, 8'h00}};
  codec_control_word_register_bank i_codec_control_word_register_bank (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .serial_data_i(sdi), .input_frame_sync_i(fsi), .serial_data_o(sdo),
    .output_frame_sync_o(fso), .serial_clock_o(sclk), .divided_master_clock_o(), .reset_busy_o(busy),
    .mode_o(mode), .power_o(power), .gain_control_o(gain), .output_timing_control_o(timing),
    .analog_routing_control_o(routing));
  host_port_model i_host_port_model (.core_clk_i(core_clk_i), .serial_clock_i(sclk), .reply_data_i(sdo),
    .reply_sync_i(fso), .serial_data_o(sdi), .frame_sync_o(fsi));
  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("mismatches %0d, checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    i_host_port_model.wait_sample();
    i_host_port_model.send_word({2'b10, 3'h0, sel, d});
  endtask : wr
  // reset pin low two cycles, then release checks up to the first frame sync
  task automatic hw_reset();
    rst_n_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    check({mode, power}, 32'h0);
    check({gain, timing, routing}, 32'h0);
    check(busy, 32'h1);
    repeat (4) @(negedge core_clk_i);
    check(busy, 32'h0);
    n = 4;
    while (!fso && n < 2100) begin
      @(negedge core_clk_i);
      n++;
    end
    check(n >= 2048 && n <= 2060, 32'h1);
  endtask : hw_reset
  initial begin
    hw_reset();
    foreach (rows[i]) begin
      wr(rows[i].sel, rows[i].wr);
      i_host_port_model.send_word({2'b11, 3'h0, rows[i].sel, 8'h00});
      i_host_port_model.get_reply(reply);
      check(reply, {2'b11, 3'h0, rows[i].sel, rows[i].rd});
    end
    // device count 7, echo on, three sections powered
    check({mode, power}, {15'h0780, 4'he});
    check({gain, timing, routing}, 24'ha53fe0);
    i_host_port_model.wait_sample();
    i_host_port_model.send_word(16'h9a12);
    i_host_port_model.get_reply(reply);
    check(reply, 16'h9212);
    check(power, 4'he);
    i_host_port_model.wait_sample();
    i_host_port_model.send_word(16'h0240);
    check(power, 4'he);
    wr(3'h2, 8'h01);
    check(power[3:1], 3'h7);
    wr(3'h2, 8'h20);
    check(power, 4'h2);
    wr(3'h0, 8'h80);
    check({mode, power}, 32'h0);
    check({gain, timing, routing}, 32'h0);
    i_host_port_model.send_word(16'hc000);
    i_host_port_model.get_reply(reply);
    check(reply, 16'hc000);
    wr(3'h0, 8'h0f);
    check({mode, power}, {15'h7800, 4'h0});
    wr(3'h0, 8'h01);
    check({mode, power}, {15'h4000, 4'h0});
    wr(3'h3, 8'h11);
    check(gain, 8'h00);
    hw_reset();
    wr(3'h3, 8'h11);
    check(gain, 8'h11);
    complete_run();
  end
  initial begin
    repeat (80000) @(posedge core_clk_i);
    mismatches++;
    complete_run();
  end
endmodule : tb_codec_control_word_register_bank
